// ===== rtl/tcid_trace_capability_id_reg4.sv
// What this block does
// - bits 31:28 read one vmid comparator
// - bits 27:24 read one context comparator
// - bits 23:20 read one single-shot control
// - bits 19:16 read 0111, eight selector pairs
// - bits 15:12 read zero pe inputs
// - bit 8 reads zero, no address compare
// - bits 7:4 read zero value comparators
// - bits 3:0 read four address pairs
// - selected by the fixed read encoding
// - level 0 read is undefined, no data
// - level 1 trap bit traps to 1
// - level 1 then level-2 bit traps to 2, with level 2 enabled
// - fine-grained id trap also goes to 2, with level 2 enabled
// - else level-3 bit traps to 3, else return
// - level 2 checks level-2 then level-3 bits
// - level 3 traps on level-3 bit, else return
// - every trap carries class 0x18
`timescale 1ns/1ps
`default_nettype none
module tcid_trace_capability_id_reg4
   import tcid_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic readReq,
   input wire logic [1:0] op0,
   input wire logic [2:0] op1,
   input wire logic [3:0] crn,
   input wire logic [3:0] crm,
   input wire logic [2:0] op2,
   input wire logic [1:0] currentPrivilegeLevel,
   input wire logic el2Enabled,
   input wire logic level1TraceAccessTrap,
   input wire logic level2TraceAccessTrap,
   input wire logic level3TraceAccessTrap,
   input wire logic fineGrainedTrapEnable,
   input wire logic traceIdReadFineTrap,
   output logic respValid,
   output logic respReturn,
   output logic respUndefined,
   output logic respTrap,
   output logic [1:0] respTrapLevel,
   output logic [5:0] respExcClass,
   output logic [63:0] readData
);

   // the fixed register value; no write path exists, so it cannot change
   // reset has nothing to do here: the value is wired, not stored
   wire logic [63:0] traceCapabilityIdFour = {
      TCID_UPPER_VAL,
      TCID_VMID_VAL,
      TCID_CIDC_VAL,
      TCID_SSCC_VAL,
      TCID_RSPAIR_VAL,
      TCID_PC_VAL,
      TCID_RSV_VAL,
      TCID_DAC_VAL,
      TCID_DVC_VAL,
      TCID_ACPAIR_VAL
   };

   // carrier to the decision logic
   // the decision is combinational; only the answer is registered
   tcid_access_if acc ();

   // request fields go straight to the checker; they share this clock
   assign acc.op0 = op0;
   assign acc.op1 = op1;
   assign acc.crn = crn;
   assign acc.crm = crm;
   assign acc.op2 = op2;
   assign acc.level = currentPrivilegeLevel;
   assign acc.el2Enabled = el2Enabled;
   assign acc.l1Trap = level1TraceAccessTrap;
   assign acc.l2Trap = level2TraceAccessTrap;
   assign acc.l3Trap = level3TraceAccessTrap;
   assign acc.fineTrapEnable = fineGrainedTrapEnable;
   assign acc.idReadFineTrap = traceIdReadFineTrap;

   // privilege and trap decision
   tcid_access_check u_tcid_access_check (
      .acc(acc.checker_side)
   );

   // decoded outcome of the request in this cycle
   wire logic takeReq = readReq && (acc.outcome != TCID_OUT_NONE);
   wire logic isReturn = (acc.outcome == TCID_OUT_RETURN);
   wire logic isUndef = (acc.outcome == TCID_OUT_UNDEF);
   wire logic isTrap = (acc.outcome == TCID_OUT_TRAP);

   // next values of the answer registers
   logic respValid_reg;
   logic respReturn_reg;
   logic respUndefined_reg;
   logic respTrap_reg;
   logic [1:0] respTrapLevel_reg;
   logic [5:0] respExcClass_reg;
   logic [63:0] readData_reg;
   wire logic respValid_next = takeReq;
   wire logic respReturn_next = takeReq && isReturn;
   wire logic respUndefined_next = takeReq && isUndef;
   wire logic respTrap_next = takeReq && isTrap;
   wire logic [1:0] respTrapLevel_next = (takeReq && isTrap) ? acc.trapLevel : TCID_LEVEL0;
   // one class for all trap targets
   wire logic [5:0] respExcClass_next = (takeReq && isTrap) ? TCID_EXC_CLASS : 6'h00;
   // data only leaves on a permitted read; undefined and trapped reads show zero
   // zero rather than the last value, so nothing leaks into a trapped read
   wire logic [63:0] readData_next = (takeReq && isReturn) ? traceCapabilityIdFour :
      64'h0000_0000_0000_0000;

   // answer registers: one-cycle pulse after the request edge
   // reset is synchronous, so the pulse flags clear on the first low edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         respValid_reg <= 1'b0;
         respReturn_reg <= 1'b0;
         respUndefined_reg <= 1'b0;
         respTrap_reg <= 1'b0;
      end else begin
         respValid_reg <= respValid_next;
         respReturn_reg <= respReturn_next;
         respUndefined_reg <= respUndefined_next;
         respTrap_reg <= respTrap_next;
      end
   end

   // answer payload registers, cleared outside an answer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         respTrapLevel_reg <= TCID_LEVEL0;
         respExcClass_reg <= 6'h00;
         readData_reg <= 64'h0000_0000_0000_0000;
      end else begin
         respTrapLevel_reg <= respTrapLevel_next;
         respExcClass_reg <= respExcClass_next;
         readData_reg <= readData_next;
      end
   end

   // outputs come straight from flip-flops
   assign respValid = respValid_reg;
   assign respReturn = respReturn_reg;
   assign respUndefined = respUndefined_reg;
   assign respTrap = respTrap_reg;
   assign respTrapLevel = respTrapLevel_reg;
   assign respExcClass = respExcClass_reg;
   assign readData = readData_reg;

   // checks, all in the core clock domain
   // the disable looks at the present reset level, so an attempt must not
   // straddle the release edge; the bench lowers readReq before releasing
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // shorthand for a selected read request
   // decoded again here apart from the checker, so a slip there shows up
   wire logic selReq = readReq && (op0 == TCID_SEL_OP0) && (op1 == TCID_SEL_OP1) &&
      (crn == TCID_SEL_CRN) && (crm == TCID_SEL_CRM) && (op2 == TCID_SEL_OP2);

   // a permitted read at level 3 carries the vmid count
   property p_vmid_field;
      selReq && (currentPrivilegeLevel == TCID_LEVEL3) && !level3TraceAccessTrap
         |=> respReturn && (readData[TCID_VMID_LSB +: 4] == 4'h1);
   endproperty
   a_vmid_field: assert property (p_vmid_field)
      else $error("vmid comparator count wrong");

   // context comparator count on any returned value
   property p_cidc_field;
      respReturn |-> readData[TCID_CIDC_LSB +: 4] == 4'h1;
   endproperty
   a_cidc_field: assert property (p_cidc_field)
      else $error("context comparator count wrong");

   // single-shot control count
   property p_sscc_field;
      respReturn |-> readData[TCID_SSCC_LSB +: 4] == 4'h1;
   endproperty
   a_sscc_field: assert property (p_sscc_field)
      else $error("single-shot control count wrong");

   // selector pairs encoded as count minus one
   property p_rspair_field;
      respReturn |-> (readData[TCID_RSPAIR_LSB +: 4] + 5'h01) == 5'h08;
   endproperty
   a_rspair_field: assert property (p_rspair_field)
      else $error("selector pair field wrong");

   // no pe comparator inputs
   property p_pc_field;
      respReturn |-> readData[TCID_PC_LSB +: 4] == 4'h0;
   endproperty
   a_pc_field: assert property (p_pc_field)
      else $error("pe comparator field not zero");

   // data address compare unsupported
   property p_dac_bit;
      respReturn |-> !readData[TCID_DAC_BIT];
   endproperty
   a_dac_bit: assert property (p_dac_bit)
      else $error("address compare bit set");

   // no data value comparators
   property p_dvc_field;
      respReturn |-> readData[TCID_DVC_LSB +: 4] == 4'h0;
   endproperty
   a_dvc_field: assert property (p_dvc_field)
      else $error("value comparator field not zero");

   // four address comparator pairs
   property p_acpair_field;
      respReturn |-> readData[TCID_ACPAIR_LSB +: 4] == 4'h4;
   endproperty
   a_acpair_field: assert property (p_acpair_field)
      else $error("address pair field wrong");

   // only the selecting encoding produces an answer, exactly one cycle later
   property p_select;
      readReq |=> (respValid == $past(selReq));
   endproperty
   a_select: assert property (p_select)
      else $error("answer does not match encoding");

   // level 0 reads are undefined and hand out no data
   property p_level0;
      selReq && (currentPrivilegeLevel == TCID_LEVEL0)
         |=> respUndefined && !respTrap && !respReturn && (readData == 64'h0000_0000_0000_0000);
   endproperty
   a_level0: assert property (p_level0)
      else $error("level 0 read not undefined");

   // level-1 trap bit wins at level 1
   property p_l1_trap;
      selReq && (currentPrivilegeLevel == TCID_LEVEL1) && level1TraceAccessTrap
         |=> respTrap && (respTrapLevel == TCID_LEVEL1) && (respExcClass == 6'h18);
   endproperty
   a_l1_trap: assert property (p_l1_trap)
      else $error("level 1 trap not taken");

   // coarse level-2 bit at level 1
   property p_l1_to_l2;
      selReq && (currentPrivilegeLevel == TCID_LEVEL1) && !level1TraceAccessTrap &&
         el2Enabled && level2TraceAccessTrap
         |=> respTrap && (respTrapLevel == TCID_LEVEL2);
   endproperty
   a_l1_to_l2: assert property (p_l1_to_l2)
      else $error("level 1 read not trapped to level 2");

   // fine-grained id trap at level 1, only with level 2 enabled
   property p_l1_fine;
      selReq && (currentPrivilegeLevel == TCID_LEVEL1) && !level1TraceAccessTrap &&
         !level2TraceAccessTrap && fineGrainedTrapEnable && traceIdReadFineTrap
         |=> $past(el2Enabled) ? (respTrap && (respTrapLevel == TCID_LEVEL2)) :
         (respTrapLevel != TCID_LEVEL2);
   endproperty
   a_l1_fine: assert property (p_l1_fine)
      else $error("fine-grained trap misrouted");

   // level-3 bit catches what is left at level 1, otherwise data returns
   property p_l1_last;
      selReq && (currentPrivilegeLevel == TCID_LEVEL1) && !level1TraceAccessTrap &&
         !(el2Enabled && (level2TraceAccessTrap ||
         (fineGrainedTrapEnable && traceIdReadFineTrap)))
         |=> (respTrap && (respTrapLevel == TCID_LEVEL3)) == $past(level3TraceAccessTrap) &&
         (respReturn == !$past(level3TraceAccessTrap));
   endproperty
   a_l1_last: assert property (p_l1_last)
      else $error("level 1 fallthrough wrong");

   // level 2 checks its own bit before the level-3 bit
   property p_l2;
      selReq && (currentPrivilegeLevel == TCID_LEVEL2) && level2TraceAccessTrap
         |=> respTrap && (respTrapLevel == TCID_LEVEL2) && (respExcClass == 6'h18);
   endproperty
   a_l2: assert property (p_l2)
      else $error("level 2 own trap not taken");

   // then the level-3 bit, then the value
   property p_l2_order;
      selReq && (currentPrivilegeLevel == TCID_LEVEL2) ##1 1'b1
         |-> ($past(level2TraceAccessTrap) ? (respTrapLevel == TCID_LEVEL2) :
         $past(level3TraceAccessTrap) ? (respTrapLevel == TCID_LEVEL3) : respReturn);
   endproperty
   a_l2_order: assert property (p_l2_order)
      else $error("level 2 priority wrong");

   // level 3 traps to itself or returns
   property p_l3;
      selReq && (currentPrivilegeLevel == TCID_LEVEL3) && level3TraceAccessTrap
         |=> respTrap && (respTrapLevel == TCID_LEVEL3) && !respReturn;
   endproperty
   a_l3: assert property (p_l3)
      else $error("level 3 trap not taken");

   // upper word and reserved bits always zero, value never changes
   property p_reserved;
      respValid |-> (readData[63:32] == 32'h0000_0000) && (readData[11:9] == 3'h0) &&
         (!respReturn || (readData == 64'h0000_0000_1117_0004));
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits or value wrong");

   // class and trap flag go together, for every target level
   property p_class;
      respValid |-> (respTrap == (respExcClass == 6'h18)) &&
         (respTrap == (respTrapLevel != TCID_LEVEL0));
   endproperty
   a_class: assert property (p_class)
      else $error("exception class mismatch");

   // level 3 without its trap bit hands the value back
   property p_l3_return;
      selReq && (currentPrivilegeLevel == TCID_LEVEL3) && !level3TraceAccessTrap
         |=> respReturn && !respTrap && (respTrapLevel == TCID_LEVEL0);
   endproperty
   a_l3_return: assert property (p_l3_return)
      else $error("level 3 read not returned");

   // exactly one kind of answer per attempt
   property p_one_kind;
      respValid |-> $onehot({respReturn, respUndefined, respTrap});
   endproperty
   a_one_kind: assert property (p_one_kind)
      else $error("answer kind not unique");

   // no attempt, no answer: the four flags and the data fall back after one cycle
   property p_quiet;
      !readReq |=> !respValid && !respReturn && !respUndefined && !respTrap &&
         (readData == 64'h0000_0000_0000_0000);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("answer without an attempt");

   // data never leaks out of a refused or trapped read
   property p_data_gate;
      !respReturn |-> readData == 64'h0000_0000_0000_0000;
   endproperty
   a_data_gate: assert property (p_data_gate)
      else $error("data shown without a permitted read");

   // class and target level stay zero whenever no trap is shown
   property p_no_trap_quiet;
      !respTrap |-> (respExcClass == 6'h00) && (respTrapLevel == TCID_LEVEL0);
   endproperty
   a_no_trap_quiet: assert property (p_no_trap_quiet)
      else $error("class or level without a trap");

endmodule // tcid_trace_capability_id_reg4
`default_nettype wire

// ===== rtl/tcid_pkg.sv
// shared constants for the trace capability id register, bank four
package tcid_pkg;

   // system-register read encoding that selects this register
   localparam logic [1:0] TCID_SEL_OP0 = 2'h2;
   localparam logic [2:0] TCID_SEL_OP1 = 3'h1;
   localparam logic [3:0] TCID_SEL_CRN = 4'h0;
   localparam logic [3:0] TCID_SEL_CRM = 4'hC;
   localparam logic [2:0] TCID_SEL_OP2 = 3'h7;

   // privilege level codes
   localparam logic [1:0] TCID_LEVEL0 = 2'h0;
   localparam logic [1:0] TCID_LEVEL1 = 2'h1;
   localparam logic [1:0] TCID_LEVEL2 = 2'h2;
   localparam logic [1:0] TCID_LEVEL3 = 2'h3;

   // exception class carried by every trap from this access
   localparam logic [5:0] TCID_EXC_CLASS = 6'h18;

   // field positions inside the 64-bit value
   localparam int TCID_VMID_LSB = 28;
   localparam int TCID_CIDC_LSB = 24;
   localparam int TCID_SSCC_LSB = 20;
   localparam int TCID_RSPAIR_LSB = 16;
   localparam int TCID_PC_LSB = 12;
   localparam int TCID_RSV_LSB = 9;
   localparam int TCID_DAC_BIT = 8;
   localparam int TCID_DVC_LSB = 4;
   localparam int TCID_ACPAIR_LSB = 0;

   // fixed field values (reset value equals these, nothing is writable)
   localparam logic [3:0] TCID_VMID_VAL = 4'h1;
   localparam logic [3:0] TCID_CIDC_VAL = 4'h1;
   localparam logic [3:0] TCID_SSCC_VAL = 4'h1;
   localparam logic [3:0] TCID_RSPAIR_VAL = 4'h7;
   localparam logic [3:0] TCID_PC_VAL = 4'h0;
   localparam logic [2:0] TCID_RSV_VAL = 3'h0;
   localparam logic [0:0] TCID_DAC_VAL = 1'h0;
   localparam logic [3:0] TCID_DVC_VAL = 4'h0;
   localparam logic [3:0] TCID_ACPAIR_VAL = 4'h4;
   localparam logic [31:0] TCID_UPPER_VAL = 32'h0000_0000;

   // outcome of one read attempt, one-hot
   typedef enum logic [3:0] {
      TCID_OUT_NONE = 4'b0001,
      TCID_OUT_RETURN = 4'b0010,
      TCID_OUT_UNDEF = 4'b0100,
      TCID_OUT_TRAP = 4'b1000
   } tcid_outcome_type;

endpackage

// ===== rtl/tcid_access_if.sv
`timescale 1ns/1ps
`default_nettype none
// request fields and access decision between the top and the checker
interface tcid_access_if;
   import tcid_pkg::*;
   logic [1:0] op0;
   logic [2:0] op1;
   logic [3:0] crn;
   logic [3:0] crm;
   logic [2:0] op2;
   logic [1:0] level;
   logic el2Enabled;
   logic l1Trap;
   logic l2Trap;
   logic l3Trap;
   logic fineTrapEnable;
   logic idReadFineTrap;
   tcid_outcome_type outcome;
   logic [1:0] trapLevel;

   modport checker_side (
      input op0, op1, crn, crm, op2, level, el2Enabled,
      input l1Trap, l2Trap, l3Trap, fineTrapEnable, idReadFineTrap,
      output outcome, trapLevel
   );
   modport core_side (
      output op0, op1, crn, crm, op2, level, el2Enabled,
      output l1Trap, l2Trap, l3Trap, fineTrapEnable, idReadFineTrap,
      input outcome, trapLevel
   );
endinterface
`default_nettype wire

// ===== rtl/tcid_access_check.sv
`timescale 1ns/1ps
`default_nettype none
// combinational privilege and trap decision for one read attempt
module tcid_access_check
   import tcid_pkg::*;
(
   tcid_access_if.checker_side acc
);
   // encoding match
   wire logic hit = (acc.op0 == TCID_SEL_OP0) && (acc.op1 == TCID_SEL_OP1) &&
      (acc.crn == TCID_SEL_CRN) && (acc.crm == TCID_SEL_CRM) &&
      (acc.op2 == TCID_SEL_OP2);
   // level decode
   wire logic atL0 = (acc.level == TCID_LEVEL0);
   wire logic atL1 = (acc.level == TCID_LEVEL1);
   wire logic atL2 = (acc.level == TCID_LEVEL2);
   wire logic atL3 = (acc.level == TCID_LEVEL3);
   // level-2 cause at level 1: coarse bit first, then fine-grained path
   wire logic l1ToL2Cause = acc.el2Enabled &&
      (acc.l2Trap || (acc.fineTrapEnable && acc.idReadFineTrap));
   // per-level trap conditions in priority order
   wire logic trapTo1 = atL1 && acc.l1Trap;
   wire logic trapTo2 = (atL1 && !acc.l1Trap && l1ToL2Cause) ||
      (atL2 && acc.l2Trap);
   wire logic trapTo3 = (atL1 && !acc.l1Trap && !l1ToL2Cause && acc.l3Trap) ||
      (atL2 && !acc.l2Trap && acc.l3Trap) || (atL3 && acc.l3Trap);

   // level 0 never reaches the trap checks
   assign acc.outcome = !hit ? TCID_OUT_NONE :
      atL0 ? TCID_OUT_UNDEF :
      (trapTo1 || trapTo2 || trapTo3) ? TCID_OUT_TRAP : TCID_OUT_RETURN;
   assign acc.trapLevel = trapTo1 ? TCID_LEVEL1 : trapTo2 ? TCID_LEVEL2 :
      trapTo3 ? TCID_LEVEL3 : TCID_LEVEL0;
endmodule // tcid_access_check
`default_nettype wire

// ===== tb/tcid_trace_capability_id_reg4_test.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the read-only trace capability id register
module tcid_trace_capability_id_reg4_test;
   import tcid_pkg::*;

   // full register image, built field by field from the documented values
   localparam logic [63:0] IMAGE = {32'h0000_0000, 4'h1, 4'h1, 4'h1, 4'h7, 4'h0, 3'h0, 1'h0,
      4'h0, 4'h4};
   // the one encoding that selects this register
   localparam logic [15:0] GOOD = {TCID_SEL_OP0, TCID_SEL_OP1, TCID_SEL_CRN, TCID_SEL_CRM,
      TCID_SEL_OP2};

   logic clk = 1'b0; // core clock, 25 MHz
   logic rstn = 1'b0; // synchronous reset, active low
   logic readReq = 1'b1; // held high through reset on purpose
   logic [1:0] op0 = TCID_SEL_OP0;
   logic [2:0] op1 = TCID_SEL_OP1;
   logic [3:0] crn = TCID_SEL_CRN;
   logic [3:0] crm = TCID_SEL_CRM;
   logic [2:0] op2 = TCID_SEL_OP2;
   logic [1:0] currentPrivilegeLevel = 2'h3;
   logic el2Enabled = 1'b0;
   logic level1TraceAccessTrap = 1'b0;
   logic level2TraceAccessTrap = 1'b0;
   logic level3TraceAccessTrap = 1'b0;
   logic fineGrainedTrapEnable = 1'b0;
   logic traceIdReadFineTrap = 1'b0;
   logic respValid;
   logic respReturn;
   logic respUndefined;
   logic respTrap;
   logic [1:0] respTrapLevel;
   logic [5:0] respExcClass;
   logic [63:0] readData;
   int badCount = 0; // mismatches seen
   int samplesChecked = 0; // comparisons made

   tcid_trace_capability_id_reg4 u_tcid_trace_capability_id_reg4 (
      .clk(clk), .rstn(rstn), .readReq(readReq), .op0(op0), .op1(op1), .crn(crn), .crm(crm),
      .op2(op2), .currentPrivilegeLevel(currentPrivilegeLevel), .el2Enabled(el2Enabled),
      .level1TraceAccessTrap(level1TraceAccessTrap),
      .level2TraceAccessTrap(level2TraceAccessTrap),
      .level3TraceAccessTrap(level3TraceAccessTrap),
      .fineGrainedTrapEnable(fineGrainedTrapEnable), .traceIdReadFineTrap(traceIdReadFineTrap),
      .respValid(respValid), .respReturn(respReturn), .respUndefined(respUndefined),
      .respTrap(respTrap), .respTrapLevel(respTrapLevel), .respExcClass(respExcClass),
      .readData(readData)
   );

   // free-running clock, 40 ns period
   initial begin
      forever #20 clk = ~clk;
   end

   // one comparison; case inequality so an unknown never passes
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      samplesChecked++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // expected outcome {kind, target level}: kind 1 return, 2 undefined, 3 trap
   // trap-bit vector b is {el2, l1, l2, l3, fineEnable, idReadFine}
   function automatic logic [3:0] expect_of(input logic [1:0] lvl, input logic [5:0] b);
      case (lvl)
         2'h0: return 4'h8;
         2'h1: begin
            if (b[4]) return 4'hD;
            else if (b[5] && (b[3] || (b[1] && b[0]))) return 4'hE;
            else if (b[2]) return 4'hF;
            else return 4'h4;
         end
         2'h2: begin
            if (b[3]) return 4'hE;
            else if (b[2]) return 4'hF;
            else return 4'h4;
         end
         default: begin
            if (b[2]) return 4'hF;
            else return 4'h4;
         end
      endcase
   endfunction

   // launch one attempt just after this edge
   task automatic drive(input logic [15:0] enc, input logic [1:0] lvl, input logic [5:0] b);
      readReq <= 1'b1;
      {op0, op1, crn, crm, op2} <= enc;
      currentPrivilegeLevel <= lvl;
      {el2Enabled, level1TraceAccessTrap, level2TraceAccessTrap, level3TraceAccessTrap,
         fineGrainedTrapEnable, traceIdReadFineTrap} <= b;
   endtask

   // judge the answer one edge after the attempt was taken
   task automatic judge(input logic [15:0] enc, input logic [1:0] lvl, input logic [5:0] b);
      logic [3:0] e;
      logic hit;
      logic trp;
      logic ret;
      e = expect_of(lvl, b);
      hit = (enc === GOOD);
      trp = hit && (e[3:2] == 2'h3);
      ret = hit && (e[3:2] == 2'h1);
      check(respValid, hit, "valid");
      check(respReturn, ret, "return");
      check(respUndefined, hit && (e[3:2] == 2'h2), "undefined");
      check(respTrap, trp, "trap");
      check(respTrapLevel, trp ? e[1:0] : 2'h0, "trap level");
      check(respExcClass, trp ? TCID_EXC_CLASS : 6'h00, "class");
      check(readData, ret ? IMAGE : 64'h0, "data");
   endtask

   // single attempt, answer, then the answer must drop after one cycle
   task automatic one_read(input logic [15:0] enc, input logic [1:0] lvl, input logic [5:0] b);
      @(posedge clk);
      drive(enc, lvl, b);
      @(posedge clk);
      readReq <= 1'b0;
      #1;
      judge(enc, lvl, b);
      @(posedge clk);
      #1;
      check({respValid, respReturn, respUndefined, respTrap}, 4'h0, "flags fall");
      check({respTrapLevel, respExcClass}, 8'h00, "trap info falls");
      check(readData, 64'h0000_0000_0000_0000, "data falls");
   endtask

   // outputs stay quiet through reset even with a matching request held up
   task automatic test_reset;
      repeat (15) @(posedge clk);
      // lowered one edge before release, so no attempt straddles the release edge
      readReq <= 1'b0;
      #1;
      check({respValid, respReturn, respUndefined, respTrap}, 4'h0, "flags in reset");
      check(readData, 64'h0000_0000_0000_0000, "data in reset");
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      check({respValid, respReturn, respUndefined, respTrap}, 4'h0, "flags released");
      check(readData, 64'h0000_0000_0000_0000, "data released");
      $display("test reset done");
   endtask

   // each field of a permitted read at level three
   task automatic test_fields;
      one_read(GOOD, TCID_LEVEL3, 6'h00);
      @(posedge clk);
      drive(GOOD, TCID_LEVEL3, 6'h00);
      @(posedge clk);
      readReq <= 1'b0;
      #1;
      check(readData[31:28], 4'h1, "virt ctx comparators");
      check(readData[27:24], 4'h1, "ctx comparators");
      check(readData[23:20], 4'h1, "single shot controls");
      check(readData[19:16], 4'h7, "selector pairs");
      check(readData[15:12], 4'h0, "pe inputs");
      check(readData[8], 1'h0, "data addr compare");
      check(readData[7:4], 4'h0, "data value comparators");
      check(readData[3:0], 4'h4, "addr pairs");
      check({readData[63:32], readData[11:9]}, 35'h0, "reserved zero");
      $display("test fields done");
   endtask

   // every level against every combination of the six trap controls
   task automatic test_access_table;
      for (int l = 0; l < 4; l++) begin
         for (int b = 0; b < 64; b++) begin
            one_read(GOOD, l[1:0], b[5:0]);
         end
      end
      $display("test access table done");
   endtask

   // any single flipped encoding bit must go unanswered
   task automatic test_encoding;
      for (int i = 0; i < 16; i++) begin
         one_read(GOOD ^ (16'h0001 << i), TCID_LEVEL3, 6'h00);
      end
      $display("test encoding done");
   endtask

   // requests on consecutive edges: return, then undefined, then trap to three
   task automatic test_back_to_back;
      @(posedge clk);
      drive(GOOD, TCID_LEVEL3, 6'h00);
      @(posedge clk);
      drive(GOOD, TCID_LEVEL0, 6'h3F);
      #1;
      judge(GOOD, TCID_LEVEL3, 6'h00);
      @(posedge clk);
      drive(GOOD, TCID_LEVEL2, 6'h04);
      #1;
      judge(GOOD, TCID_LEVEL0, 6'h3F);
      @(posedge clk);
      readReq <= 1'b0;
      #1;
      judge(GOOD, TCID_LEVEL2, 6'h04);
      $display("test back to back done");
   endtask

   // counts, verdict, end of run
   task automatic tallyAndFinish;
      $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // watchdog: a hung run counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      tallyAndFinish();
   end

   // main sequence
   initial begin
      test_reset();
      test_fields();
      test_access_table();
      test_encoding();
      test_back_to_back();
      tallyAndFinish();
   end

endmodule // tcid_trace_capability_id_reg4_test
`default_nettype wire
